// *** hdl/tdpsc_core.sv ***
`timescale 1ns/1ps
// Function
// - Gate pin low in sine, dc, pulse opens every switch.
// - Gate pin high in those modes passes route_select unchanged.
// - Power-down holds all switches open regardless of anything.
// - Digital mode takes the pin as a ones-density bitstream.
// - Bitstream sampled once every sixteen master clocks.
// - Digital mode output range comes from analog_range_select.
// - Align rise zeroes output, next sample eight edges later, then every 16.
// - Each sample reaches the output update four clocks later.
// - Output flagged settled 400 clocks after an align rise.
// - Sine mode align rise resets waveform to zero crossing next edge.
// - A late align edge may shift alignment one clock.
// - Pulse mode code from first level when align low, second when high.
// - Pulse code follows align level change on the next clock.
// - Sleep low enters power-down, tristates outputs, opens switch.
// - Leaving power-down performs a restart reset, without repeating power-on reset or default load.
// - Device stays in reset two clocks after sleep rises.
// - Power-on reset lasts 2^16 clocks with output held at zero.
// - After power-on reset defaults load: sine, switch off.
// - route_select maps to switch elements per fixed table.
// - Old switches open before new ones close.
module tdpsc_core #(
  parameter int POR_CYCLES = tdpsc_pkg::POR_HOLD_CLK
) (
  ref_clk,
  arst_n,
  clk_en,
  route_gate_or_bitstream_pin,
  align_input,
  sleep_or_restart_n,
  cfg,
  gen_ready,
  dac_code,
  dac_range,
  bit_valid,
  bit_value,
  wave_zero,
  out_settled,
  switch_ctrl,
  out_hiz,
  read_line_oe,
  in_reset,
  in_power_down,
  cfg_default_load
);
  import tdpsc_pkg::*;
  input wire logic ref_clk;
  input wire logic arst_n;
  input wire logic clk_en;
  input wire logic route_gate_or_bitstream_pin;
  input wire logic align_input;
  input wire logic sleep_or_restart_n;
  input wire tdpsc_pkg::tdpsc_cfg_type cfg;
  input wire logic gen_ready;
  output logic [4:0] dac_code;
  output logic [2:0] dac_range;
  output logic bit_valid;
  output logic bit_value;
  output logic wave_zero;
  output logic out_settled;
  output logic [4:0] switch_ctrl;
  output logic out_hiz;
  output logic read_line_oe;
  output logic in_reset;
  output logic in_power_down;
  output logic cfg_default_load;

  localparam logic [16:0] POR_LAST = 17'(POR_CYCLES - 1);
  localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_PERIOD_CLK - 1);
  localparam logic [3:0] ALIGN_LOAD = 4'(SAMPLE_PERIOD_CLK - ALIGN_FIRST_SAMPLE_CLK + 1);
  localparam logic [8:0] SETTLE_LAST = 9'(ALIGN_SETTLE_CLK - 1);
  localparam logic [1:0] RST_LAST = 2'(RESTART_HOLD_CLK - 1);

  tdpsc_state_type state_q;
  logic [16:0] por_cnt_q;
  logic por_done_q;
  logic [1:0] rst_cnt_q;
  logic align_s1_q;
  logic align_s2_q;
  logic align_rise;
  logic [3:0] phase_q;
  logic [SAMPLE_TO_UPDATE_CLK-1:0] pipe_v_q;
  logic [SAMPLE_TO_UPDATE_CLK-1:0] pipe_b_q;
  logic [8:0] settle_q;
  logic [4:0] sw_target;
  logic [4:0] sw_q;
  logic [4:0] code_q;
  logic [2:0] range_q;
  logic zero_q;
  logic settled_q;
  logic hiz_q;
  logic rst_q;
  logic pd_q;
  logic dflt_q;
  logic oe_q;
  logic running;
  logic digital;
  tdpsc_word_type buf_in;
  tdpsc_word_type buf_out;
  logic buf_in_ready;
  logic buf_out_valid;
  logic vld_q;
  logic bit_q;

  assign running = (state_q == TDPSC_ST_RUN);
  assign digital = (cfg.mode == MODE_DIGITAL);

  ////////////////////////////////////////////////////////////////
  // Reset and power-down sequencing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= TDPSC_ST_RESET;
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
      rst_cnt_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        TDPSC_ST_RESET: begin
          if (!sleep_or_restart_n) begin
            state_q <= TDPSC_ST_SLEEP;
          end else if (!por_done_q) begin
            por_cnt_q <= por_cnt_q + 17'h00001;
            if (por_cnt_q == POR_LAST) begin
              por_done_q <= 1'b1;
              state_q <= TDPSC_ST_RUN;
            end
          end else begin
            rst_cnt_q <= rst_cnt_q + 2'h1;
            if (rst_cnt_q == RST_LAST) begin
              state_q <= TDPSC_ST_RUN;
            end
          end
        end
        TDPSC_ST_RUN: begin
          if (!sleep_or_restart_n) begin
            state_q <= TDPSC_ST_SLEEP;
          end
        end
        TDPSC_ST_SLEEP: begin
          if (sleep_or_restart_n) begin
            state_q <= TDPSC_ST_RESET;
            rst_cnt_q <= 2'h0;
          end
        end
        default: state_q <= TDPSC_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 1'b1;
      pd_q <= 1'b0;
      hiz_q <= 1'b1;
      dflt_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (clk_en) begin
      rst_q <= !running;
      pd_q <= (state_q == TDPSC_ST_SLEEP);
      hiz_q <= (state_q == TDPSC_ST_SLEEP) || !sleep_or_restart_n;
      dflt_q <= (state_q == TDPSC_ST_RESET) && !por_done_q && (por_cnt_q == POR_LAST) && sleep_or_restart_n;
      oe_q <= (state_q != TDPSC_ST_SLEEP) && sleep_or_restart_n;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Align edge detection
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      align_s1_q <= 1'b0;
      align_s2_q <= 1'b0;
    end else if (clk_en) begin
      align_s1_q <= align_input;
      align_s2_q <= align_s1_q;
    end
  end

  // One extra register stage absorbs a late edge
  assign align_rise = align_s1_q && !align_s2_q;

  ////////////////////////////////////////////////////////////////
  // Bitstream sampling
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= '0;
      pipe_v_q <= '0;
      pipe_b_q <= '0;
    end else if (clk_en) begin
      if (!running || !digital) begin
        phase_q <= '0;
        pipe_v_q <= '0;
      end else if (align_rise) begin
        phase_q <= ALIGN_LOAD;
        pipe_v_q <= '0;
      end else begin
        phase_q <= (phase_q == SAMPLE_LAST) ? 4'h0 : phase_q + 4'h1;
        pipe_v_q <= {pipe_v_q[SAMPLE_TO_UPDATE_CLK-2:0], phase_q == SAMPLE_LAST};
        pipe_b_q <= {pipe_b_q[SAMPLE_TO_UPDATE_CLK-2:0], route_gate_or_bitstream_pin};
      end
    end
  end

  assign buf_in.zero = 1'b0;
  assign buf_in.align = 1'b0;
  assign buf_in.bit_val = pipe_b_q[SAMPLE_TO_UPDATE_CLK-1];

  tdpsc_buf2 u_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .clr(!running || align_rise),
    .in_valid(pipe_v_q[SAMPLE_TO_UPDATE_CLK-1]),
    .in_ready(buf_in_ready),
    .in_word(buf_in),
    .out_valid(buf_out_valid),
    .out_ready(gen_ready),
    .out_word(buf_out)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      vld_q <= 1'b0;
      bit_q <= 1'b0;
    end else if (clk_en) begin
      vld_q <= buf_out_valid && gen_ready && running;
      bit_q <= buf_out.bit_val;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Settling and zeroing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_q <= '0;
      settled_q <= 1'b0;
      zero_q <= 1'b1;
    end else if (clk_en) begin
      zero_q <= !running || (align_rise && (digital || cfg.mode == MODE_SINE));
      if (!running || (digital && align_rise)) begin
        settle_q <= '0;
        settled_q <= !digital && running;
      end else if (digital && !settled_q) begin
        settle_q <= settle_q + 9'h001;
        settled_q <= (settle_q == SETTLE_LAST);
      end else begin
        settled_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Code and range selection
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      code_q <= PULSE_DEFAULT;
      range_q <= RANGE_DEFAULT;
    end else if (clk_en) begin
      code_q <= align_input ? cfg.second_pulse_level : cfg.first_pulse_level;
      range_q <= cfg.analog_range_select;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output switch control
  always_comb begin
    sw_target = route_decode(cfg.route_select);
    if (!running || digital || !route_gate_or_bitstream_pin) begin
      sw_target = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_q <= '0;
    end else if (clk_en) begin
      if ((sw_q & ~sw_target) != '0) begin
        sw_q <= sw_q & sw_target;
      end else begin
        sw_q <= sw_target;
      end
    end
  end

  assign dac_code = code_q;
  assign dac_range = range_q;
  assign bit_valid = vld_q;
  assign bit_value = bit_q;
  assign wave_zero = zero_q;
  assign out_settled = settled_q;
  assign switch_ctrl = sw_q;
  assign out_hiz = hiz_q;
  assign read_line_oe = oe_q;
  assign in_reset = rst_q;
  assign in_power_down = pd_q;
  assign cfg_default_load = dflt_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  chk_gate_opens_switch: assert property (clk_en && !route_gate_or_bitstream_pin |=> switch_ctrl == '0)
    else $error("switch not opened by gate pin");
  chk_sleep_opens_switch: assert property (in_power_down |-> switch_ctrl == '0)
    else $error("switch closed in power-down");
  chk_sleep_hiz: assert property (in_power_down |-> out_hiz && !read_line_oe)
    else $error("outputs driven in power-down");
  chk_break_before_make: assert property (
    ((switch_ctrl & ~$past(switch_ctrl)) != '0) |-> (($past(switch_ctrl) & ~switch_ctrl) == '0))
    else $error("switch closed while another opened");
  chk_sample_spacing: assert property (
    clk_en && running && digital && phase_q == SAMPLE_LAST && !align_rise |=> phase_q == 4'h0)
    else $error("sample phase wrap wrong");
  chk_align_phase: assert property (clk_en && running && digital && align_rise |=> phase_q == ALIGN_LOAD)
    else $error("align did not reload phase");
  chk_sample_latency: assert property (
    clk_en && running && digital && !align_rise && phase_q == SAMPLE_LAST
    ##1 (clk_en && running && digital && !align_rise) [*3] |=> pipe_v_q[SAMPLE_TO_UPDATE_CLK-1])
    else $error("sample not delivered after four clocks");
  chk_pulse_select: assert property (
    clk_en |=> dac_code == ($past(align_input) ? $past(cfg.second_pulse_level) : $past(cfg.first_pulse_level)))
    else $error("pulse code mismatch");
  chk_restart_hold: assert property (
    clk_en && state_q == TDPSC_ST_SLEEP && sleep_or_restart_n ##1 clk_en |=> !running)
    else $error("restart hold too short");
  chk_sine_zero: assert property (clk_en && running && cfg.mode == MODE_SINE && align_rise |=> wave_zero)
    else $error("sine not zeroed on align");

  cov_align_digital: cover property (@(posedge ref_clk) running && digital && align_rise);
  cov_settled: cover property (@(posedge ref_clk) running && digital && $rose(settled_q));
  cov_sleep_exit: cover property (@(posedge ref_clk) state_q == TDPSC_ST_SLEEP ##1 state_q == TDPSC_ST_RESET);
  cov_switch_swap: cover property (@(posedge ref_clk) switch_ctrl == 5'h05 ##[1:3] switch_ctrl == 5'h0A);

endmodule // tdpsc_core

// *** hdl/tdpsc_pkg.sv ***
package tdpsc_pkg;

  // Master clock figures
  localparam real MCLK_MHZ = 100.0;
  localparam int SAMPLE_PERIOD_CLK = 16;
  localparam int ALIGN_FIRST_SAMPLE_CLK = 8;
  localparam int SAMPLE_TO_UPDATE_CLK = 4;
  localparam int ALIGN_SETTLE_CLK = 400;
  localparam int RESTART_HOLD_CLK = 2;
  localparam int POR_HOLD_CLK = 65536;
  localparam int ALIGN_LOW_MIN_CLK = 2;

  // Output mode encoding
  localparam logic [1:0] MODE_SINE = 2'h0;
  localparam logic [1:0] MODE_DC = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] MODE_DIGITAL = 2'h3;

  // Defaults after reset
  localparam logic [2:0] ROUTE_DEFAULT = 3'h0;
  localparam logic [1:0] MODE_DEFAULT = MODE_SINE;
  localparam logic [2:0] RANGE_DEFAULT = 3'h0;
  localparam logic [4:0] PULSE_DEFAULT = 5'h00;

  // Switch element vector: bit0 S1 .. bit4 S5
  localparam int SWITCH_W = 5;

  typedef enum logic [2:0] {
    TDPSC_ST_RESET = 3'b001,
    TDPSC_ST_RUN = 3'b010,
    TDPSC_ST_SLEEP = 3'b100
  } tdpsc_state_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] route_select;
    logic [2:0] analog_range_select;
    logic [4:0] first_pulse_level;
    logic [4:0] second_pulse_level;
  } tdpsc_cfg_type;

  typedef struct packed {
    logic zero;
    logic align;
    logic bit_val;
  } tdpsc_word_type;

  function automatic logic [SWITCH_W-1:0] route_decode(input logic [2:0] sel);
    case (sel)
      3'h1: route_decode = 5'h05;
      3'h2: route_decode = 5'h0A;
      3'h3: route_decode = 5'h03;
      3'h4: route_decode = 5'h0C;
      3'h5: route_decode = 5'h01;
      3'h6: route_decode = 5'h04;
      3'h7: route_decode = 5'h10;
      default: route_decode = 5'h00;
    endcase
  endfunction

endpackage

// *** hdl/tdpsc_buf2.sv ***
`timescale 1ns/1ps
module tdpsc_buf2 (
  ref_clk,
  arst_n,
  clk_en,
  clr,
  in_valid,
  in_ready,
  in_word,
  out_valid,
  out_ready,
  out_word
);
  import tdpsc_pkg::*;
  input wire logic ref_clk;
  input wire logic arst_n;
  input wire logic clk_en;
  input wire logic clr;
  input wire logic in_valid;
  output logic in_ready;
  input wire tdpsc_pkg::tdpsc_word_type in_word;
  output logic out_valid;
  input wire logic out_ready;
  output tdpsc_pkg::tdpsc_word_type out_word;

  tdpsc_word_type mem_q [2];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_word = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (clk_en) begin
      if (clr) begin
        rd_q <= 1'b0;
        wr_q <= 1'b0;
        cnt_q <= 2'h0;
      end else begin
        if (push) begin
          mem_q[wr_q] <= in_word;
          wr_q <= ~wr_q;
        end
        if (pop) begin
          rd_q <= ~rd_q;
        end
        cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
    end
  end

  chk_no_overflow: assert property (@(posedge ref_clk) disable iff (!arst_n) cnt_q <= 2'h2)
    else $error("buffer count above depth");
  chk_stall_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clk_en && !clr && out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("stalled word lost");

endmodule // tdpsc_buf2

// *** bench/tdpsc_host_model.sv ***
`timescale 1ns/1ps
module tdpsc_host_model (
  ref_clk,
  align_input,
  route_gate_or_bitstream_pin,
  sleep_or_restart_n
);
  input wire logic ref_clk;
  output logic align_input;
  output logic route_gate_or_bitstream_pin;
  output logic sleep_or_restart_n;

  initial begin
    align_input = 1'b0;
    route_gate_or_bitstream_pin = 1'b0;
    sleep_or_restart_n = 1'b1;
  end

  ////////////////////////////////////////
  task automatic set_gate(input logic v);
    @(negedge ref_clk);
    route_gate_or_bitstream_pin = v;
  endtask

  task automatic set_align(input logic v);
    @(negedge ref_clk);
    align_input = v;
  endtask

  task automatic set_sleep(input logic v);
    @(negedge ref_clk);
    sleep_or_restart_n = v; // Callers keep it low two clocks or more
  endtask

  task automatic align_rise();
    @(negedge ref_clk);
    align_input = 1'b0;
    repeat (2) @(negedge ref_clk); // Low two clocks before the rise
    align_input = 1'b1;
  endtask

  task automatic send_bits(input logic [7:0] bits, input int n);
    for (int k = 0; k < n; k++) begin
      for (int c = 0; c < 16; c++) begin
        route_gate_or_bitstream_pin = (c >= 4 && c < 12) ? bits[k] : ~bits[k]; // Valid around phase 8
        @(negedge ref_clk);
      end
    end
  endtask
endmodule // tdpsc_host_model

// *** bench/test_test_dac_pin_sync_control.sv ***
`timescale 1ns/1ps
module test_test_dac_pin_sync_control;
  import tdpsc_pkg::*;
  localparam int POR_SIM = 16;
  localparam logic [4:0] SW_TBL [8] = '{5'h00, 5'h05, 5'h0A, 5'h03, 5'h0C, 5'h01, 5'h04, 5'h10};
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic gen_ready = 1'b1;
  tdpsc_cfg_type cfg = '0;
  logic route_gate_or_bitstream_pin, align_input, sleep_or_restart_n;
  logic [4:0] dac_code, switch_ctrl;
  logic [2:0] dac_range;
  logic bit_valid, bit_value, wave_zero, out_settled, out_hiz;
  logic read_line_oe, in_reset, in_power_down, cfg_default_load;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic got_q[$];
  int got_t[$];

  initial begin
    forever #5 ref_clk = ~ref_clk; // Stands in for the master clock
  end

  tdpsc_core #(.POR_CYCLES(POR_SIM)) u_dut (.ref_clk, .arst_n, .clk_en, .route_gate_or_bitstream_pin,
    .align_input, .sleep_or_restart_n, .cfg, .gen_ready, .dac_code, .dac_range, .bit_valid, .bit_value,
    .wave_zero, .out_settled, .switch_ctrl, .out_hiz, .read_line_oe, .in_reset, .in_power_down, .cfg_default_load);
  tdpsc_host_model u_host (.ref_clk, .align_input, .route_gate_or_bitstream_pin, .sleep_or_restart_n);

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (bit_valid === 1'b1) begin
      got_q.push_back(bit_value);
      got_t.push_back(cyc);
    end
  end

  ////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  task automatic t_por();
    int cnt = 0;
    int loads = 0;
    while (in_reset !== 1'b0 && cnt < 100) begin
      check("por_zero", 8'({wave_zero, switch_ctrl}), 8'h20);
      tick(1);
      cnt++;
      loads += int'(cfg_default_load === 1'b1);
    end
    check("por_length", 8'(cnt >= POR_SIM && cnt <= POR_SIM + 4), 8'h01);
    check("default_load", 8'(loads), 8'h01);
    check("default_switch", 8'(switch_ctrl), 8'h00);
    $display("Test por done");
  endtask

  task automatic t_switch();
    logic [4:0] old;
    logic ok;
    for (int m = 0; m < 3; m++) begin
      cfg.mode = 2'(m);
      u_host.set_gate(1'b1);
      tick(3);
      for (int r = 0; r < 8; r++) begin
        old = switch_ctrl;
        cfg.route_select = 3'(r);
        for (int c = 0; c < 4; c++) begin
          tick(1);
          ok = (switch_ctrl === old) || (switch_ctrl === (old & SW_TBL[r])) || (switch_ctrl === SW_TBL[r]);
          check("switch_no_overlap", 8'(ok), 8'h01);
        end
        check("switch_route", 8'(switch_ctrl), 8'(SW_TBL[r]));
      end
      u_host.set_gate(1'b0);
      tick(3);
      check("switch_gate_low", 8'(switch_ctrl), 8'h00);
    end
    cfg.route_select = 3'h1;
    u_host.set_gate(1'b1);
    tick(3);
    $display("Test switch done");
  endtask

  task automatic t_sleep();
    int cnt = 0;
    u_host.set_sleep(1'b0);
    tick(3);
    check("sleep_switch", 8'(switch_ctrl), 8'h00);
    check("sleep_hiz", 8'({out_hiz, read_line_oe, in_power_down}), 8'h05);
    u_host.set_sleep(1'b1);
    tick(1);
    check("restart_hold", 8'(in_reset), 8'h01);
    while (in_reset !== 1'b0 && cnt < 20) begin
      tick(1);
      cnt++;
    end
    check("restart_length", 8'(cnt >= 1 && cnt <= 4), 8'h01);
    tick(3);
    check("run_again", 8'({out_hiz, in_power_down, switch_ctrl}), 8'(SW_TBL[1]));
    $display("Test sleep done");
  endtask

  task automatic t_pulse();
    cfg.mode = MODE_PULSE;
    cfg.first_pulse_level = 5'h11;
    cfg.second_pulse_level = 5'h07;
    u_host.set_align(1'b0);
    tick(2);
    check("pulse_low", 8'(dac_code), 8'h11);
    for (int k = 0; k < 2; k++) begin
      u_host.set_align(1'b1);
      tick(1);
      check("pulse_high", 8'(dac_code), 8'h07);
      u_host.set_align(1'b0);
      tick(1);
      check("pulse_back", 8'(dac_code), 8'h11);
    end
    $display("Test pulse done");
  endtask

  task automatic t_freeze();
    clk_en = 1'b0;
    u_host.set_align(1'b1);
    tick(3);
    check("freeze_code", 8'(dac_code), 8'h11);
    clk_en = 1'b1;
    tick(1);
    check("thaw_code", 8'(dac_code), 8'h07);
    u_host.set_align(1'b0);
    tick(2);
    $display("Test freeze done");
  endtask

  task automatic t_sine();
    int cnt = 0;
    int highs = 0;
    cfg.mode = MODE_SINE;
    tick(4);
    check("sine_idle", 8'(wave_zero), 8'h00);
    u_host.align_rise();
    while (wave_zero !== 1'b1 && cnt < 10) begin
      tick(1);
      cnt++;
    end
    check("sine_zero_delay", 8'(cnt >= 1 && cnt <= 4), 8'h01);
    tick(2);
    repeat (20) begin
      tick(1);
      highs += int'(wave_zero === 1'b1);
    end
    check("sine_steady", 8'(highs), 8'h00);
    $display("Test sine done");
  endtask

  task automatic t_digital();
    int rise;
    int base;
    int zs = 0;
    logic [7:0] bits = 8'h2D;
    cfg.mode = MODE_DIGITAL;
    cfg.analog_range_select = 3'h5;
    tick(2);
    check("range", 8'(dac_range), 8'h05);
    u_host.align_rise();
    rise = cyc;
    base = got_t.size();
    fork
      u_host.send_bits(bits, 6);
      repeat (4) begin
        tick(1);
        zs += int'(wave_zero === 1'b1);
      end
    join
    while (base < got_t.size() && got_t[base] < rise + 10) base++;
    check("align_zero", 8'(zs > 0), 8'h01);
    check("sample_count", 8'(got_t.size() - base >= 6), 8'h01);
    check("first_sample", 8'(got_t[base] - rise >= 12 && got_t[base] - rise <= 20), 8'h01);
    check("sample_spacing", 8'(got_t[base + 1] - got_t[base]), 8'h10);
    for (int k = 0; k < 6; k++) check("sample_bit", 8'(got_q[base + k]), 8'(bits[k]));
    while (cyc < rise + 395) tick(1);
    check("not_settled", 8'(out_settled), 8'h00);
    while (cyc < rise + 410) tick(1);
    check("settled", 8'(out_settled), 8'h01);
    $display("Test digital done");
  endtask

  task automatic t_stall();
    int rise;
    int s0 = 0;
    int g = 0;
    u_host.align_rise();
    rise = cyc;
    fork
      u_host.send_bits(8'h1B, 5);
      begin
        while ((got_t.size() == 0 || got_t[$] < rise + 10) && g < 40) begin
          tick(1);
          g++;
        end
        gen_ready = 1'b0;
        s0 = got_q.size();
        tick(60);
        check("stall_hold", 8'(got_q.size() - s0), 8'h00);
        gen_ready = 1'b1;
      end
    join
    tick(4);
    check("stall_first", 8'(got_q[s0]), 8'h01);
    check("stall_second", 8'(got_q[s0 + 1]), 8'h00);
    $display("Test stall done");
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    wrap_up();
  end

  initial begin
    repeat (6) @(negedge ref_clk);
    arst_n = 1'b1;
    t_por();
    t_switch();
    t_sleep();
    t_pulse();
    t_freeze();
    t_sine();
    t_digital();
    t_stall();
    wrap_up();
  end
endmodule // test_test_dac_pin_sync_control
